// >>> rtl/oc_regs.svh
// Register map, field positions, mode codes and reset values of the
// output compare unit.
// Assumes inclusion by bare name from the top module and the bench.
//
// Notes on behaviour
// - Enable bit turns the unit on or off.
// - Idle-stop bit halts the unit during processor idle, except the fault input in mode 111.
// - Wide select compares full 32-bit values.
// - Narrow select compares low 16 bits only.
// - Fault flag set by hardware, cleared by a mode write once the fault is gone.
// - Fault flag reads zero outside fault PWM mode.
// - Timebase select picks timebase B or A.
// - Mode 111 is PWM with fault input active.
// - Mode 110 is PWM ignoring the fault input.
// - Mode 101: start low, then repeating pulses.
// - Mode 100: start low, then one pulse.
// - Mode 011 toggles the pin per match.
// - Mode 010: start high, match drives low.
// - Mode 001: start low, match drives high.
// - Mode 000 disables output, unit stays powered.
`ifndef OC_REGS_SVH
`define OC_REGS_SVH

`define CTL_OFS 8'h00
`define PRI_OFS 8'h04
`define SEC_OFS 8'h08
`define STAT_OFS 8'h0c
`define CLR_OFS 8'h10
`define EN_OFS 8'h14

`define ON_BIT 15
`define IDLE_STOP_BIT 13
`define WIDE_BIT 5
`define FLAG_BIT 4
`define TSEL_BIT 3
`define MODE_MSB 2
`define MODE_LSB 0
`define NARROW_W 16

`define MODE_OFF 3'h0
`define MODE_SET_HIGH 3'h1
`define MODE_SET_LOW 3'h2
`define MODE_TOGGLE 3'h3
`define MODE_ONE_PULSE 3'h4
`define MODE_PULSE_TRAIN 3'h5
`define MODE_PWM 3'h6
`define MODE_PWM_FAULT 3'h7

`define EV_W 3
`define REG_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> rtl/oc_pkg.sv
// Types used by the output compare unit and its assertions.
// Assumes the constants header is on the include path.
package oc_pkg;
  // Writable control fields of the control register.
  typedef struct packed {
    logic on;
    logic idle_stop;
    logic wide;
    logic tsel;
    logic [2:0] mode;
  } ctrl_t;

  // Events that set the sticky status bits, bit 0 first from the right.
  typedef struct packed {
    logic flt;
    logic sec;
    logic pri;
  } events_t;

  // Pulse sequencer states.
  typedef enum logic [3:0] {
    pulse_idle = 4'b0001,
    pulse_rise = 4'b0010,
    pulse_fall = 4'b0100,
    pulse_done = 4'b1000
  } pulse_t;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    sel_ctl = 3'h0,
    sel_pri = 3'h1,
    sel_sec = 3'h2,
    sel_stat = 3'h3,
    sel_clr = 3'h4,
    sel_en = 3'h5,
    sel_none = 3'h7
  } reg_sel_t;
endpackage : oc_pkg

// >>> rtl/output_compare_pwm_unit.sv
// Output compare unit with pulse and PWM modes behind an AXI4-Lite slave.
// Assumes timebases come from logic on clk and the fault pin is
// asynchronous and active low.
`timescale 1ns/1ns
`default_nettype none
`include "oc_regs.svh"

module output_compare_pwm_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address and data.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timebases and processor state.
  input wire logic [31:0] timebase_a,
  input wire logic [31:0] timebase_b,
  input wire logic cpu_idle,
  // Pins and interrupt.
  input wire logic fault_in_n,
  output logic compare_output_pin,
  output logic irq
);

  // ***************************************************************
  // Helpers
  // ***************************************************************

  // Maps a byte address onto a register; misaligned is unmapped.
  function automatic oc_pkg::reg_sel_t reg_decode(input logic [7:0] a);
    case (a)
      `CTL_OFS: reg_decode = oc_pkg::sel_ctl;
      `PRI_OFS: reg_decode = oc_pkg::sel_pri;
      `SEC_OFS: reg_decode = oc_pkg::sel_sec;
      `STAT_OFS: reg_decode = oc_pkg::sel_stat;
      `CLR_OFS: reg_decode = oc_pkg::sel_clr;
      `EN_OFS: reg_decode = oc_pkg::sel_en;
      default: reg_decode = oc_pkg::sel_none;
    endcase
  endfunction : reg_decode

  // Replaces the bytes of a word that the strobes select.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
    merge_bytes = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge_bytes[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge_bytes

  // Packs control fields and the fault flag into a word.
  function automatic logic [31:0] ctl_word(input oc_pkg::ctrl_t c,
      input logic flag);
    ctl_word = `REG_RESET;
    ctl_word[`ON_BIT] = c.on;
    ctl_word[`IDLE_STOP_BIT] = c.idle_stop;
    ctl_word[`WIDE_BIT] = c.wide;
    ctl_word[`FLAG_BIT] = flag;
    ctl_word[`TSEL_BIT] = c.tsel;
    ctl_word[`MODE_MSB:`MODE_LSB] = c.mode;
  endfunction : ctl_word

  // ***************************************************************
  // Bus slave
  // ***************************************************************

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire;
  oc_pkg::reg_sel_t wr_sel;

  // A write commits once both halves are held and no response waits.
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_sel = reg_decode(awaddr_q);

  // Write address and data are taken in either order.
  always_ff @(posedge clk) begin
    if (reset) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= `REG_RESET;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
      if (bvalid_q && bready) begin
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == oc_pkg::sel_none) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************

  oc_pkg::ctrl_t ctl_q, ctl_d;
  logic [31:0] pri_q, sec_q, wr_ctl_word;
  logic [`EV_W-1:0] stat_q, en_q, clr_v;
  logic wr_ctl, wr_mode, flt_q, irq_q;
  oc_pkg::events_t ev;

  assign wr_ctl = wr_fire && (wr_sel == oc_pkg::sel_ctl);
  assign wr_mode = wr_ctl && wstrb_q[0];
  assign wr_ctl_word = merge_bytes(ctl_word(ctl_q, 1'b0), wdata_q, wstrb_q);
  assign clr_v = (wr_fire && wr_sel == oc_pkg::sel_clr && wstrb_q[0]) ?
                 wdata_q[`EV_W-1:0] : {`EV_W{1'b0}};

  // Next control value; the fault flag position is not writable.
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d.on = wr_ctl_word[`ON_BIT];
      ctl_d.idle_stop = wr_ctl_word[`IDLE_STOP_BIT];
      ctl_d.wide = wr_ctl_word[`WIDE_BIT];
      ctl_d.tsel = wr_ctl_word[`TSEL_BIT];
      ctl_d.mode = wr_ctl_word[`MODE_MSB:`MODE_LSB];
    end
  end

  // Control, compare values and interrupt enable.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_q <= '0;
      pri_q <= `REG_RESET;
      sec_q <= `REG_RESET;
      en_q <= {`EV_W{1'b0}};
    end else begin
      ctl_q <= ctl_d;
      if (wr_fire && wr_sel == oc_pkg::sel_pri) begin
        pri_q <= merge_bytes(pri_q, wdata_q, wstrb_q);
      end
      if (wr_fire && wr_sel == oc_pkg::sel_sec) begin
        sec_q <= merge_bytes(sec_q, wdata_q, wstrb_q);
      end
      if (wr_fire && wr_sel == oc_pkg::sel_en && wstrb_q[0]) begin
        en_q <= wdata_q[`EV_W-1:0];
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      stat_q <= {`EV_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr_v) | ev;
      irq_q <= |(stat_q & en_q);
    end
  end

  // Read channel; the fault flag reads only in fault PWM mode.
  always_ff @(posedge clk) begin
    if (reset) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= `REG_RESET;
      rresp_q <= `RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `RESP_OKAY;
      case (reg_decode(araddr))
        oc_pkg::sel_ctl: rdata_q <= ctl_word(ctl_q,
            flt_q && ctl_q.mode == `MODE_PWM_FAULT);
        oc_pkg::sel_pri: rdata_q <= pri_q;
        oc_pkg::sel_sec: rdata_q <= sec_q;
        oc_pkg::sel_stat: rdata_q <= {{(32-`EV_W){1'b0}}, stat_q};
        oc_pkg::sel_en: rdata_q <= {{(32-`EV_W){1'b0}}, en_q};
        oc_pkg::sel_clr: rdata_q <= `REG_RESET;
        default: begin
          rdata_q <= `REG_RESET;
          rresp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ***************************************************************
  // Compare engine
  // ***************************************************************

  logic fault_meta_q, fault_sync_q, fault_s, halt, run;
  logic moved, match_p, match_s, period_start, init_evt, pin_q;
  logic [31:0] tb_sel, tb_cmp, tb_q, pri_cmp, sec_cmp;
  oc_pkg::pulse_t pulse_q;

  // Two-stage synchroniser for the asynchronous fault pin.
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_meta_q <= 1'b1;
      fault_sync_q <= 1'b1;
    end else begin
      fault_meta_q <= fault_in_n;
      fault_sync_q <= fault_meta_q;
    end
  end

  assign fault_s = !fault_sync_q;
  assign halt = ctl_q.idle_stop && cpu_idle;
  assign run = ctl_q.on && !halt;
  assign tb_sel = ctl_q.tsel ? timebase_b : timebase_a;
  // Narrow mode masks both sides to the low half.
  assign tb_cmp = ctl_q.wide ? tb_sel :
                  {{`NARROW_W{1'b0}}, tb_sel[`NARROW_W-1:0]};
  assign pri_cmp = ctl_q.wide ? pri_q :
                   {{`NARROW_W{1'b0}}, pri_q[`NARROW_W-1:0]};
  assign sec_cmp = ctl_q.wide ? sec_q :
                   {{`NARROW_W{1'b0}}, sec_q[`NARROW_W-1:0]};
  // A match counts once per new timebase value, not while it holds.
  assign moved = tb_cmp != tb_q;
  assign match_p = run && moved && tb_cmp == pri_cmp;
  assign match_s = run && moved && tb_cmp == sec_cmp;
  assign period_start = run && moved && tb_cmp == `REG_RESET;
  // Enabling or changing the mode loads the starting pin level.
  assign init_evt = wr_ctl && ctl_d.on &&
                    (ctl_d.mode != ctl_q.mode || !ctl_q.on);
  // One driver for the event word: fault, secondary, primary.
  assign ev = {ctl_q.on && ctl_q.mode == `MODE_PWM_FAULT && fault_s &&
               !flt_q, match_s, match_p};

  // Last compared timebase value.
  always_ff @(posedge clk) begin
    if (reset) begin
      tb_q <= `REG_RESET;
    end else begin
      tb_q <= tb_cmp;
    end
  end

  // Fault flag; only a mode rewrite with the fault gone clears it.
  always_ff @(posedge clk) begin
    if (reset) begin
      flt_q <= 1'b0;
    end else if (ctl_q.on && ctl_q.mode == `MODE_PWM_FAULT && fault_s) begin
      flt_q <= 1'b1;
    end else if (wr_mode && !fault_s) begin
      flt_q <= 1'b0;
    end
  end

  // Pulse sequencer for single and continuous pulse modes.
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_q <= oc_pkg::pulse_idle;
    end else if (init_evt) begin
      pulse_q <= (ctl_d.mode == `MODE_ONE_PULSE ||
                  ctl_d.mode == `MODE_PULSE_TRAIN) ?
                 oc_pkg::pulse_rise : oc_pkg::pulse_idle;
    end else if (!ctl_q.on) begin
      pulse_q <= oc_pkg::pulse_idle;
    end else begin
      case (pulse_q)
        oc_pkg::pulse_rise: begin
          if (match_p) begin
            pulse_q <= oc_pkg::pulse_fall;
          end
        end
        oc_pkg::pulse_fall: begin
          if (match_s) begin
            pulse_q <= (ctl_q.mode == `MODE_PULSE_TRAIN) ?
                       oc_pkg::pulse_rise : oc_pkg::pulse_done;
          end
        end
        oc_pkg::pulse_idle: pulse_q <= oc_pkg::pulse_idle;
        oc_pkg::pulse_done: pulse_q <= oc_pkg::pulse_done;
        default: pulse_q <= oc_pkg::pulse_idle;
      endcase
    end
  end

  // Output pin level for every mode.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_q <= 1'b0;
    end else if (init_evt) begin
      pin_q <= (ctl_d.mode == `MODE_SET_LOW);
    end else if (!ctl_q.on || ctl_q.mode == `MODE_OFF) begin
      pin_q <= 1'b0;
    end else if (ctl_q.mode == `MODE_PWM_FAULT && (fault_s || flt_q)) begin
      pin_q <= 1'b0;
    end else if (!halt) begin
      case (ctl_q.mode)
        `MODE_SET_HIGH: if (match_p) pin_q <= 1'b1;
        `MODE_SET_LOW: if (match_p) pin_q <= 1'b0;
        `MODE_TOGGLE: if (match_p) pin_q <= !pin_q;
        `MODE_ONE_PULSE, `MODE_PULSE_TRAIN: begin
          if (pulse_q == oc_pkg::pulse_rise && match_p) begin
            pin_q <= 1'b1;
          end else if (pulse_q == oc_pkg::pulse_fall && match_s) begin
            pin_q <= 1'b0;
          end
        end
        `MODE_PWM, `MODE_PWM_FAULT: begin
          // Duty match wins over period start, so zero duty stays low.
          if (match_p) begin
            pin_q <= 1'b0;
          end else if (period_start) begin
            pin_q <= 1'b1;
          end
        end
        default: pin_q <= 1'b0;
      endcase
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign compare_output_pin = pin_q;
  assign irq = irq_q;

  // ***************************************************************
  // Assertions
  // ***************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  enable_off_a: assert property (
    !ctl_q.on && !wr_fire |=> !pin_q)
    else $error("pin not low while disabled");
  idle_hold_a: assert property (
    halt && ctl_q.on && ctl_q.mode != `MODE_PWM_FAULT && !wr_fire
    |=> $stable(pin_q))
    else $error("pin moved during idle stop");
  match_toggle_a: assert property (
    ctl_q.on && !halt && ctl_q.mode == `MODE_TOGGLE && !wr_fire &&
    tb_sel != $past(tb_sel) && (ctl_q.wide ? tb_sel == pri_q :
    tb_sel[`NARROW_W-1:0] == pri_q[`NARROW_W-1:0]) &&
    (ctl_q.wide || tb_sel[`NARROW_W-1:0] != $past(tb_sel[`NARROW_W-1:0]))
    |=> pin_q != $past(pin_q))
    else $error("toggle missed on match");
  flag_clear_a: assert property (
    $fell(flt_q) |-> $past(wr_mode && !fault_s))
    else $error("fault flag cleared without rewrite");
  flag_read_a: assert property (
    arvalid && arready_q && reg_decode(araddr) == oc_pkg::sel_ctl &&
    ctl_q.mode != `MODE_PWM_FAULT |=> !rdata_q[`FLAG_BIT])
    else $error("fault flag visible outside fault mode");
  fault_force_a: assert property (
    ctl_q.on && ctl_q.mode == `MODE_PWM_FAULT && fault_s && !wr_fire
    |=> !pin_q && flt_q ##1 (!pin_q || $past(wr_fire)))
    else $error("fault did not stop output");
  pwm_ignore_a: assert property (
    ctl_q.on && ctl_q.mode == `MODE_PWM && period_start && !match_p &&
    fault_s && !wr_fire |=> pin_q)
    else $error("fault affected plain pwm");
  pulse_end_a: assert property (
    ctl_q.on && !wr_fire && pulse_q == oc_pkg::pulse_fall && match_s
    |=> !pin_q && (pulse_q == (ctl_q.mode == `MODE_PULSE_TRAIN ?
    oc_pkg::pulse_rise : oc_pkg::pulse_done)))
    else $error("pulse did not end correctly");
  mode_init_a: assert property (
    init_evt |=> pin_q == (ctl_q.mode == `MODE_SET_LOW))
    else $error("wrong starting pin level");
  set_high_a: assert property (
    ctl_q.on && ctl_q.mode == `MODE_SET_HIGH && match_p && !wr_fire
    |=> pin_q ##1 (pin_q || $past(wr_fire)))
    else $error("set-high match failed");
  mode_off_a: assert property (
    ctl_q.mode == `MODE_OFF && !wr_fire |=> !pin_q)
    else $error("pin active in off mode");
  irq_level_a: assert property (
    |(stat_q & en_q) |-> ##[0:1] irq_q)
    else $error("interrupt not raised");

  single_pulse_c: cover property (pulse_q == oc_pkg::pulse_done);
  fault_hit_c: cover property ($rose(flt_q));
  pwm_cycle_c: cover property ($rose(pin_q) ##[1:50] $fell(pin_q));
  irq_c: cover property ($rose(irq_q));

endmodule : output_compare_pwm_unit
`default_nettype wire

// >>> rtl/HANDOVER_unused.sv
`timescale 1ns/1ns

// >>> testbench/load_model.sv
// Behavioural load on the compare output pin, and driver of the fault pin.
// Assumes the bench asks for a fault through fault_req, timed on clk.
`timescale 1ns/1ns
`default_nettype none

module load_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Pin side.
  input wire logic compare_output_pin,
  input wire logic fault_req,
  output logic fault_in_n,
  // Count of rising edges that the load has seen.
  output logic [15:0] rises
);
  // ****************************************
  // Fault pin and edge counter
  // ****************************************
  logic last_q;

  // The fault pin is active low and follows the request at once.
  assign fault_in_n = ~fault_req;

  // Counts each rising edge that the load sees on the pin.
  always_ff @(posedge clk) begin
    last_q <= compare_output_pin;
    if (reset) begin
      rises <= 16'h0000;
    end else if (compare_output_pin && !last_q) begin
      rises <= rises + 16'h0001;
    end
  end
endmodule : load_model

`default_nettype wire

// >>> testbench/tb_output_compare_pwm_unit.sv
// Self-checking bench of the output compare unit over AXI4-Lite.
// Assumes the constants header is on the include path; the bench drives
// both timebases by hand so that each compare match is a chosen event.
`timescale 1ns/1ns
`default_nettype none
`include "oc_regs.svh"

module tb_output_compare_pwm_unit;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam logic [31:0] NEUT = 32'h0000_7777;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic cpu_idle = 1'b0, fault_req = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] ta = NEUT, tbv = NEUT;
  logic awready, wready, bvalid, arready, rvalid, fault_in_n, pin, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd, p, s;
  logic [15:0] rises, r0;
  logic ep;
  int n_mismatch = 0;
  int num_checks = 0;

  output_compare_pwm_unit output_compare_pwm_unit_inst (
    .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .timebase_a(ta),
    .timebase_b(tbv), .cpu_idle(cpu_idle), .fault_in_n(fault_in_n),
    .compare_output_pin(pin), .irq(irq)
  );

  load_model load_model_inst (
    .clk(clk), .reset(reset), .compare_output_pin(pin),
    .fault_req(fault_req), .fault_in_n(fault_in_n), .rises(rises)
  );

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // ****************************************
  // Tasks and reference model
  // ****************************************
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pin_chk(input logic e);
    chk({31'h0, pin}, {31'h0, e});
  endtask : pin_chk

  // Write one word; the response code lands in rs.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        n_mismatch++;
        finish_test();
      end
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  // Read one word into rd; the response code lands in rs.
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        n_mismatch++;
        finish_test();
      end
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd_reg

  // Puts new timebase values on the inputs, then lets n edges pass.
  task automatic tick(input logic [31:0] a, input logic [31:0] b, input int n);
    @(posedge clk);
    ta <= a;
    tbv <= b;
    repeat (n) @(posedge clk);
  endtask : tick

  function automatic logic [31:0] ctl(input logic on, input logic idl,
      input logic wide, input logic tsel, input logic [2:0] m);
    ctl = 32'h0000_0000;
    ctl[`ON_BIT] = on;
    ctl[`IDLE_STOP_BIT] = idl;
    ctl[`WIDE_BIT] = wide;
    ctl[`TSEL_BIT] = tsel;
    ctl[`MODE_MSB:`MODE_LSB] = m;
  endfunction : ctl

  // Pin level after an event: 0 primary, 1 secondary, 2 period start.
  function automatic logic nxt(input int m, input logic cur, input int ev);
    case (m)
      1: return 1'b1;
      2: return 1'b0;
      3: return ~cur;
      4, 5: return ev == 0;
      6, 7: return ev == 2;
      default: return 1'b0;
    endcase
  endfunction : nxt

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("ERROR at %0t: watchdog ran out", $time);
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(64));
    p = {16'($urandom()), 16'h1234};
    s = {16'($urandom()), 16'h5678};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // Reset values and readback of the compare values.
    rd_reg(`CTL_OFS);
    chk(rd, `REG_RESET);
    rd_reg(`STAT_OFS);
    chk(rd, `REG_RESET);
    pin_chk(1'b0);
    wr(`PRI_OFS, p);
    wr(`SEC_OFS, s);
    rd_reg(`PRI_OFS);
    chk(rd, p);
    rd_reg(`SEC_OFS);
    chk(rd, s);
    rd_reg(8'h20);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    wr(8'h20, 32'hffff_ffff);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    // Set, clear and toggle modes on narrow matches.
    for (int m = 1; m <= 3; m++) begin
      wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'(m)));
      tick(NEUT, NEUT, 2);
      ep = (m == 2);
      pin_chk(ep);
      repeat (2) begin
        tick(p ^ 32'h0001_0000, NEUT, 3);
        ep = nxt(m, ep, 0);
        pin_chk(ep);
        tick(NEUT, NEUT, 1);
      end
    end
    // Wide compare needs all 32 bits.
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b1, 1'b0, 3'h1));
    tick(p ^ 32'h0001_0000, NEUT, 3);
    pin_chk(1'b0);
    tick(p, NEUT, 3);
    pin_chk(1'b1);
    // Mode zero, then timebase B as the source.
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b1, 3'h0));
    tick(NEUT, p, 3);
    pin_chk(1'b0);
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b1, 3'h1));
    tick(p, NEUT, 3);
    pin_chk(1'b0);
    tick(NEUT, p, 3);
    pin_chk(1'b1);
    // Disabled unit ignores matches; one idle cycle after disabling.
    wr(`CTL_OFS, ctl(1'b0, 1'b0, 1'b0, 1'b0, 3'h1));
    @(posedge clk);
    tick(p, NEUT, 3);
    pin_chk(1'b0);
    // Idle stop halts the unit; without it the unit runs on.
    wr(`CTL_OFS, ctl(1'b1, 1'b1, 1'b0, 1'b0, 3'h1));
    cpu_idle <= 1'b1;
    tick(NEUT, NEUT, 1);
    tick(p, NEUT, 3);
    pin_chk(1'b0);
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h3));
    tick(NEUT, NEUT, 1);
    tick(p, NEUT, 3);
    pin_chk(1'b1);
    cpu_idle <= 1'b0;
    // Single pulse, then a pulse train.
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h4));
    tick(NEUT, NEUT, 2);
    r0 = rises;
    for (int m = 4; m <= 5; m++) begin
      if (m == 5) wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h5));
      for (int k = 0; k < 2; k++) begin
        tick(p, NEUT, 3);
        pin_chk((m == 5) || (k == 0));
        tick(NEUT, NEUT, 1);
        tick(s, NEUT, 3);
        pin_chk(nxt(m, 1'b1, 1));
        tick(NEUT, NEUT, 1);
      end
    end
    chk({16'h0, rises - r0}, 32'h0000_0003);
    // PWM that ignores the fault pin.
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h6));
    tick(32'h0, NEUT, 3);
    pin_chk(nxt(6, 1'b0, 2));
    tick(p, NEUT, 3);
    pin_chk(nxt(6, 1'b1, 0));
    tick(NEUT, NEUT, 1);
    fault_req <= 1'b1;
    tick(NEUT, NEUT, 3);
    tick(32'h0, NEUT, 6);
    pin_chk(nxt(6, 1'b0, 2));
    rd_reg(`CTL_OFS);
    chk(rd, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h6));
    fault_req <= 1'b0;
    // PWM with the fault pin acting.
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h7));
    tick(NEUT, NEUT, 1);
    tick(32'h0, NEUT, 3);
    pin_chk(1'b1);
    fault_req <= 1'b1;
    tick(32'h0, NEUT, 6);
    pin_chk(1'b0);
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h7));
    rd_reg(`CTL_OFS);
    chk(rd, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h7) | 32'h10);
    tick(NEUT, NEUT, 1);
    tick(32'h0, NEUT, 3);
    pin_chk(1'b0);
    fault_req <= 1'b0;
    tick(NEUT, NEUT, 6);
    rd_reg(`CTL_OFS);
    chk(rd, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h7) | 32'h10);
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h7));
    rd_reg(`CTL_OFS);
    chk(rd, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h7));
    tick(32'h0, NEUT, 3);
    pin_chk(1'b1);
    wr(`CTL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h6));
    rd_reg(`CTL_OFS);
    chk(rd, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h6));
    // Interrupt raised, masked and cleared; status is read only.
    wr(`CLR_OFS, 32'h0000_0007);
    wr(`STAT_OFS, 32'hffff_ffff);
    rd_reg(`STAT_OFS);
    chk(rd, 32'h0000_0000);
    wr(`EN_OFS, 32'h0000_0001);
    tick(32'h0, NEUT, 1);
    tick(p, NEUT, 3);
    rd_reg(`STAT_OFS);
    chk(rd, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    wr(`EN_OFS, 32'h0000_0000);
    tick(NEUT, NEUT, 2);
    chk({31'h0, irq}, 32'h0);
    wr(`EN_OFS, 32'h0000_0001);
    tick(NEUT, NEUT, 2);
    chk({31'h0, irq}, 32'h1);
    wr(`CLR_OFS, 32'h0000_0001);
    tick(NEUT, NEUT, 2);
    chk({31'h0, irq}, 32'h0);
    rd_reg(`STAT_OFS);
    chk(rd, 32'h0000_0000);
    finish_test();
  end
endmodule : tb_output_compare_pwm_unit

`default_nettype wire
